// file: bench/tb_top.sv
// Bench: host model fills memory, then fetch rows and pointer reads.
`timescale 1ns/1ps
module tb_top;
  reg        mclk, reset_n, font_10, ptr_load, ptr_dec, host_rd, fetch_req;
  reg        cursor_here, go;
  reg  [5:0] ptr_value;
  reg  [11:0] code_row;
  wire       host_wr, fetch_valid, fetch_user, done;
  wire [7:0] host_wdata, host_rdata;
  wire [5:0] address_pointer;
  wire [4:0] fetch_pixels;
  integer    miscompares = 0, checked = 0, cyc = 0, i;
  // {font_10, cursor, user}, code, row, pixels
  reg [23:0] rows [0:9];
  ugp_top i_ugp_top (.mclk, .reset_n, .font_10, .ptr_load, .ptr_value,
    .ptr_dec, .host_wr, .host_wdata, .host_rd, .fetch_req,
    .text_code(code_row[11:4]), .fetch_row(code_row[3:0]), .cursor_here,
    .address_pointer, .host_rdata, .fetch_valid, .fetch_user, .fetch_pixels);
  ugp_host_model i_ugp_host_model (.mclk, .go, .host_wr, .host_wdata, .done);
  task chk(input [7:0] seen, input [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard, far past the run length
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  initial begin
    {reset_n, font_10, ptr_load, ptr_dec, host_rd, fetch_req, go} = 7'h00;
    {cursor_here, ptr_value, code_row} = 19'h00000;
    rows[0] = 24'h102313;
    rows[1] = 24'h10A313;
    rows[2] = 24'h107700;
    rows[3] = 24'h30771F;
    rows[4] = 24'h010300;
    rows[5] = 24'h506515;
    rows[6] = 24'h706A1F;
    rows[7] = 24'h506A1A;
    rows[8] = 24'h101008;
    rows[9] = 24'h101800;
    // Two full cycles of reset; release away from the sampling edge
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1;
    chk(host_rdata, 8'h00);
    // Non-blocking so the host model sees go one edge later, no race
    go <= 1'b1;
    wait (done === 1'b1);
    @(negedge mclk);
    chk({2'h0, address_pointer}, 8'h00);
    for (i = 0; i < 10; i = i + 1) begin
      {font_10, cursor_here} = rows[i][22:21];
      code_row = rows[i][19:8];
      fetch_req = 1;
      @(negedge mclk) fetch_req = 0;
      // Valid stands only in the cycle after the second edge
      @(negedge mclk);
      chk({fetch_valid, fetch_user, 1'b0, fetch_pixels},
        {1'b1, rows[i][20], 1'b0, rows[i][4:0]});
    end
    // Load, then read downward: filler bits come back stored
    ptr_value = 6'h05;
    ptr_load = 1;
    @(negedge mclk) ptr_load = 0;
    {ptr_dec, host_rd} = 2'h3;
    @(negedge mclk) host_rd = 0;
    chk(host_rdata, 8'hA5);
    chk({2'h0, address_pointer}, 8'h04);
    // Mid-run reset clears pointer and read byte; one stored row rechecked blank
    reset_n = 0;
    repeat (2) @(negedge mclk);
    reset_n = 1;
    chk({2'h0, address_pointer}, 8'h00);
    chk(host_rdata, 8'h00);
    code_row = 12'h023;
    fetch_req = 1;
    @(negedge mclk) fetch_req = 0;
    @(negedge mclk);
    chk({fetch_valid, fetch_user, 1'b0, fetch_pixels}, 8'hC0);
    summarize;
  end
endmodule // tb_top

// file: bench/ugp_assertions.sv
// Checker on the ports of ugp_top; bound at the foot.
`timescale 1ns/1ps
module ugp_chk (
  input wire       mclk, reset_n, font_10, ptr_load, ptr_dec, host_wr,
  input wire       host_rd, fetch_req, cursor_here, fetch_valid, fetch_user,
  input wire [5:0] ptr_value, address_pointer,
  input wire [7:0] text_code,
  input wire [3:0] fetch_row,
  input wire [4:0] fetch_pixels
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire step = (host_wr || host_rd) && !ptr_load;
  wire crow = font_10 ? fetch_row == 4'hA : fetch_row == 4'h7;
  sequence s_fr; fetch_req ##2 fetch_valid; endsequence
  AST_VL: assert property (fetch_valid == $past(fetch_req, 2))
    else $error("valid off");
  AST_USR: assert property (s_fr |-> fetch_user ==
    ($past(text_code[7:4], 2) == 4'h0)) else $error("user bad");
  AST_DARK: assert property (fetch_valid && !fetch_user
    |-> fetch_pixels == 5'h00) else $error("font lit");
  AST_CUR: assert property (fetch_req && cursor_here && crow &&
    text_code[7:4] == 4'h0 |-> ##2 fetch_pixels == 5'h1F)
    else $error("cursor");
  AST_ROW: assert property (fetch_req && !font_10 && fetch_row[3]
    |-> ##2 fetch_pixels == 5'h00) else $error("row 8 lit");
  AST_INC: assert property (step && !ptr_dec |=>
    address_pointer == $past(address_pointer) + 6'h01) else $error("inc");
  AST_DEC: assert property (step && ptr_dec |=>
    address_pointer == $past(address_pointer) - 6'h01) else $error("dec");
  AST_LD: assert property (ptr_load |=>
    address_pointer == $past(ptr_value)) else $error("load");
endmodule // ugp_chk
bind ugp_top ugp_chk i_chk (.mclk, .reset_n, .font_10, .ptr_load, .ptr_dec,
  .host_wr, .host_rd, .fetch_req, .cursor_here, .fetch_valid, .fetch_user,
  .ptr_value, .address_pointer, .text_code, .fetch_row, .fetch_pixels);

// file: bench/ugp_host_model.sv
// Host side: fills all 64 pattern bytes from pointer zero up.
`timescale 1ns/1ps
module ugp_host_model (
  input  wire       mclk, go,
  output reg        host_wr = 1'b0, done = 1'b0,
  output reg  [7:0] host_wdata = 8'h00
);
  reg [6:0] n = 7'h00;
  // 5x8 cursor rows kept dark; top bits are filler
  always @(negedge mclk) begin
    host_wr <= go && !done;
    host_wdata <= {3'h5, n[2:0] == 3'h7 ? 5'h00 : n[4:0]};
    n <= n + {6'h00, go && !done};
    done <= done || (go && n == 7'h3F);
  end
endmodule // ugp_host_model

// file: verilog/ugp_map.vh
// Constants for the user glyph pattern memory block.
// Assumes one clock domain; included by ugp_top.v and ugp_row_mux.v.
`ifndef UGP_MAP_VH
`define UGP_MAP_VH
`define UGP_AW          6
`define UGP_DW          8
`define UGP_PIX_MSB     4
`define UGP_PTR_ONE     6'h01
`define UGP_CUR_ROW8    3'h7
`define UGP_CUR_ROW10   4'hA
`define UGP_ROW8_LIMIT  4'h8
`define UGP_USER_HI     4'h0
`define UGP_CURSOR_ROW  5'h1F
`define UGP_RST_PTR     6'h00
`define UGP_RST_BYTE    8'h00
`define UGP_RST_PIX     5'h00
`define UGP_C8_HI       2
`define UGP_C8_LO       0
`define UGP_C10_HI      2
`define UGP_C10_LO      1
`define UGP_R8_MSB      2
`define UGP_USER_MSB    7
`define UGP_USER_LSB    4
`endif

// file: verilog/ugp_row_mux.v
// Row cursor merge and pixel select for one fetched glyph row.
// Assumes a registered row byte and cursor flag on the same clock.
`timescale 1ns/1ps
`include "ugp_map.vh"
module ugp_row_mux (
  input  wire [7:0] row_byte,
  input  wire       is_cursor_row,
  input  wire       cursor_on,
  output wire [4:0] pixels
);
  // Upper bits dropped; stored row ORed with a full cursor bar
  assign pixels = row_byte[`UGP_PIX_MSB:0] |
                  ((is_cursor_row & cursor_on) ? `UGP_CURSOR_ROW
                                               : `UGP_RST_PIX);
endmodule // ugp_row_mux

// file: verilog/ugp_top.v
// User glyph pattern memory with host pointer port and display fetch.
// Two-stage fetch: row read first, then cursor merge into output flops.
// Assumes host strobes and text codes are on mclk; cursor_here level too.
// Assumes the fixed font and the pixel drive sit beyond fetch_pixels.
// Assumes fetch_row stays below eight in 5x8; higher rows read blank.
`timescale 1ns/1ps
`include "ugp_map.vh"
module ugp_top #(
  parameter DEPTH = 64
) (
  input  wire       mclk,
  input  wire       reset_n,
  input  wire       font_10,
  input  wire       ptr_load,
  input  wire [5:0] ptr_value,
  input  wire       ptr_dec,
  input  wire       host_wr,
  input  wire [7:0] host_wdata,
  input  wire       host_rd,
  input  wire       fetch_req,
  input  wire [7:0] text_code,
  input  wire [3:0] fetch_row,
  input  wire       cursor_here,
  output reg  [5:0] address_pointer,
  output reg  [7:0] host_rdata,
  output reg        fetch_valid,
  output reg        fetch_user,
  output reg  [4:0] fetch_pixels
);
  // Array geometry; the address width must cover DEPTH
  localparam AW = `UGP_AW;
  localparam DW = `UGP_DW;
  localparam PW = `UGP_PIX_MSB + 1;

  // Pattern storage, one byte a row; bits 5-7 kept only for readback
  reg  [DW-1:0] glyph_pattern_ram [0:DEPTH-1];

  // Host side decode
  wire          host_access;
  reg  [AW-1:0] ptr_step_d;
  reg  [AW-1:0] ptr_d;
  reg  [DW-1:0] rdata_d;

  // Fetch address candidates for each font height
  wire [AW-1:0] addr8_w;
  wire [AW-1:0] addr10_w;
  wire          ok8_w;
  wire          crow8_w;
  wire          crow10_w;
  wire          user_code_w;

  // Fetch address chosen for the current height
  reg  [AW-1:0] fetch_addr;
  reg           row_ok;
  reg           cursor_row;
  reg  [DW-1:0] row_d;

  // Fetch stage one registers
  reg  [DW-1:0] row_q;
  reg           user_q;
  reg           crow_q;
  reg           here_q;
  reg           stage_q;

  // Stage two inputs
  wire [PW-1:0] pix_w;
  reg  [PW-1:0] pixels_d;

  // Clear loop index
  integer       i;

  // Read and write in one cycle still move the pointer only once
  assign host_access = host_wr | host_rd;

  // Step direction follows the host's level at the access edge
  always @* begin
    if (ptr_dec) begin
      ptr_step_d = address_pointer - `UGP_PTR_ONE;
    end else begin
      ptr_step_d = address_pointer + `UGP_PTR_ONE;
    end
  end

  // A load wins over a step, so a fresh address is never skipped
  always @* begin
    if (ptr_load) begin
      ptr_d = ptr_value;
    end else if (host_access) begin
      ptr_d = ptr_step_d;
    end else begin
      ptr_d = address_pointer;
    end
  end

  // Pointer register; wraps at both ends of the array
  always @(posedge mclk) begin
    if (!reset_n) begin
      address_pointer <= `UGP_RST_PTR;
    end else begin
      address_pointer <= ptr_d;
    end
  end

  // Writes land whenever asked, also while the display is fetching
  always @(posedge mclk) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        glyph_pattern_ram[i] <= `UGP_RST_BYTE;
      end
    end else if (host_wr) begin
      glyph_pattern_ram[address_pointer] <= host_wdata;
    end
  end

  // Read byte holds until the next read; a same-cycle write is not seen
  always @* begin
    if (host_rd) begin
      rdata_d = glyph_pattern_ram[address_pointer];
    end else begin
      rdata_d = host_rdata;
    end
  end

  // Read data register
  always @(posedge mclk) begin
    if (!reset_n) begin
      host_rdata <= `UGP_RST_BYTE;
    end else begin
      host_rdata <= rdata_d;
    end
  end

  // 5x8: low code bits pick one of eight glyphs, bit 3 ignored
  assign addr8_w = {text_code[`UGP_C8_HI:`UGP_C8_LO],
                    fetch_row[`UGP_R8_MSB:0]};

  // 5x10: code bits 2 and 1 pick one of four glyphs
  assign addr10_w = {text_code[`UGP_C10_HI:`UGP_C10_LO],
                     fetch_row};

  // 5x8 rows past the eighth have no storage and stay dark
  assign ok8_w = (fetch_row < `UGP_ROW8_LIMIT);

  // Cursor rows; 5x8 needs the top row bit clear or row 15 would match
  assign crow8_w  = (fetch_row == {1'b0, `UGP_CUR_ROW8});
  assign crow10_w = (fetch_row == `UGP_CUR_ROW10);

  // Clear upper nibble selects a user glyph instead of the font
  assign user_code_w = (text_code[`UGP_USER_MSB:`UGP_USER_LSB]
                        == `UGP_USER_HI);

  // Both heights share one array; 5x10 glyphs overlay 5x8 slots
  always @* begin
    if (font_10) begin
      fetch_addr = addr10_w;
      row_ok     = 1'b1;
      cursor_row = crow10_w;
    end else begin
      fetch_addr = addr8_w;
      row_ok     = ok8_w;
      cursor_row = crow8_w;
    end
  end

  // Row byte for stage one; missing rows read as blank
  always @* begin
    if (row_ok) begin
      row_d = glyph_pattern_ram[fetch_addr];
    end else begin
      row_d = `UGP_RST_BYTE;
    end
  end

  // Stage one row byte; a write lands before the next fetch sees it
  always @(posedge mclk) begin
    if (!reset_n) begin
      row_q <= `UGP_RST_BYTE;
    end else begin
      row_q <= row_d;
    end
  end

  // Stage one tags travel beside the row
  always @(posedge mclk) begin
    if (!reset_n) begin
      user_q  <= 1'b0;
      crow_q  <= 1'b0;
      here_q  <= 1'b0;
      stage_q <= 1'b0;
    end else begin
      user_q  <= user_code_w;
      crow_q  <= cursor_row;
      here_q  <= cursor_here;
      stage_q <= fetch_req;
    end
  end

  // Cursor bar ORed onto the stored row; stored bits always show
  ugp_row_mux u_row_mux (
    .row_byte      (row_q),
    .is_cursor_row (crow_q),
    .cursor_on     (here_q),
    .pixels        (pix_w)
  );

  // Font codes leave this path dark; the fixed font is outside the block
  always @* begin
    if (user_q) begin
      pixels_d = pix_w;
    end else begin
      pixels_d = `UGP_RST_PIX;
    end
  end

  // Fetch stage two: every output straight from a flip-flop
  always @(posedge mclk) begin
    if (!reset_n) begin
      fetch_valid  <= 1'b0;
      fetch_user   <= 1'b0;
      fetch_pixels <= `UGP_RST_PIX;
    end else begin
      fetch_valid  <= stage_q;
      fetch_user   <= user_q;
      fetch_pixels <= pixels_d;
    end
  end
endmodule // ugp_top
